// *** rtl/iox_top.sv ***
// Two-wire bus target with eight-bit I/O port, polarity and interrupt
`timescale 1ns/1ps
//
// Overview of operation
// [R1] Four byte registers: input, output, polarity, direction
// [R2] Master sets each pin direction via direction register
// [R3] Input register samples pins, output register drives them
// [R4] Polarity bit set inverts returned input bit
// [R5] All four registers readable over the bus
// [R6] Interrupt when input pin differs from latched value
// [R7] Interrupt is active low, open drain
// [R8] Reset loads defaults and idles the bus machine
// [R9] Address is fixed upper part plus three straps
// [R10] Eight pins, all inputs after reset
// [R11] Bus runs from static up to 400 kHz
// [R12] Spikes on serial clock and data are filtered
// [R13] Command byte after address selects register 0..3
// [R14] Pointer never auto-increments between reads
// [R15] Interrupt clears on return or input read
// [R16] Direction one means input, zero drives output
module iox_top
  import iox_pkg::*;
#(
  parameter logic [3:0] ADDR_UPPER = ADDR_UPPER_DEF
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_out,
  output logic                   o_sda_oe_n,
  input  wire logic [STRAP_W-1:0] i_addr_strap,
  input  wire logic [PORT_W-1:0] i_port_pin,
  output logic      [PORT_W-1:0] o_port_pin,
  output logic      [PORT_W-1:0] o_port_oe_n,
  output logic                   o_int_out,
  output logic                   o_int_oe_n
);

  localparam int SW = $clog2(SETTLE_CYC + 1);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The filter must stay well inside the shortest serial clock half period
  if (SPIKE_CYC * 4 >= SCL_HALF_CYC) begin : g_bad_rate
    $error("Clock too slow for a 400 kHz serial clock"); // R11
  end

  // ==========================================================================
  // Pin synchronisers and spike filters
  // ==========================================================================
  logic [FILT_W-1:0]  filt_in;
  logic [FILT_W-1:0]  filt_out;
  logic               f_scl;
  logic               f_sda;
  logic [PORT_W-1:0]  f_port;
  logic [STRAP_W-1:0] f_strap;

  // Straps, port pins, serial data and serial clock cross into the clock domain here
  assign filt_in = {i_addr_strap, i_port_pin, i_sda, i_scl};
  assign f_scl   = filt_out[0];
  assign f_sda   = filt_out[1];
  assign f_port  = filt_out[PORT_W+1:2];
  assign f_strap = filt_out[FILT_W-1:PORT_W+2];

  iox_pin_filter #(
    .W    (FILT_W),
    .FILT (SPIKE_CYC),
    .RST  (FILT_RST)
  ) u_filt (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_din     (filt_in),
    .o_dout    (filt_out)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  iox_state_t   st;
  iox_state_t   next_st;
  logic         scl_q;
  logic         sda_q;
  logic [3:0]   cnt;
  logic [7:0]   sh;
  logic [1:0]   ptr;
  logic         mst_ack;
  logic         sda_oe_n;
  logic [7:0]   in_latch;
  logic [7:0]   out_reg; // R1
  logic [7:0]   pol;
  logic [7:0]   dir;
  logic         int_oe_n;
  logic         init_done;
  logic [SW-1:0] settle;

  // ==========================================================================
  // Bus event decode
  // ==========================================================================
  wire          scl_rise;
  wire          scl_fall;
  wire          start;
  wire          stop;
  wire          byte_done;
  wire          addr_hit;
  wire [6:0]    my_addr;
  wire          rd_load;
  wire          wr_fire;
  wire          cmd_fire;
  wire          ack_now;
  wire          shift_in;
  wire [7:0]    in_view;
  wire [7:0]    rd_data;
  wire          int_cond;
  wire          next_sda_oe_n;

  // Edges and start/stop seen on the filtered lines
  assign scl_rise  = f_scl & ~scl_q;
  assign scl_fall  = ~f_scl & scl_q;
  assign start     = scl_q & f_scl & sda_q & ~f_sda;
  assign stop      = scl_q & f_scl & ~sda_q & f_sda;
  assign byte_done = scl_fall && (cnt == BYTE_BITS);

  // Target address: fixed upper nibble and three straps
  assign my_addr   = {ADDR_UPPER, f_strap}; // R9
  assign addr_hit  = (sh[7:1] == my_addr); // R9

  // Transfer strobes on a falling serial clock, except shift_in on a rising one
  assign cmd_fire  = byte_done && (st == ST_CMD); // R13
  assign wr_fire   = byte_done && (st == ST_WDAT);
  assign rd_load   = scl_fall && ((st == ST_AACK && sh[RW_BIT]) ||
                                  (st == ST_RACK && mst_ack));
  assign ack_now   = byte_done && ((st == ST_ADDR && addr_hit) ||
                                   st == ST_CMD || st == ST_WDAT);
  assign shift_in  = scl_rise && (st == ST_ADDR || st == ST_CMD || st == ST_WDAT);

  // Read data selected by the held pointer
  assign in_view   = f_port ^ pol; // R4
  assign rd_data   = (ptr == CMD_INPUT)  ? in_view :
                     (ptr == CMD_OUTPUT) ? out_reg :
                     (ptr == CMD_POL)    ? pol     : dir; // R5

  // Interrupt only for pins that are inputs and differ from the snapshot
  assign int_cond  = init_done && (|((f_port ^ in_latch) & dir)); // R6 R15

  // Data line: acks pull low, read bits release for a one
  assign next_sda_oe_n = (start || stop)          ? 1'b1     :
                         !scl_fall                ? sda_oe_n :
                         ack_now                  ? 1'b0     :
                         rd_load                  ? rd_data[7] :
                         (st == ST_RDAT && cnt != BYTE_BITS) ? sh[6] : 1'b1;

  // ==========================================================================
  // Bus target state machine
  // ==========================================================================
  // Next state, advanced on falling serial clock; start and stop win
  always_comb begin
    next_st = st;
    if (start) begin
      next_st = ST_ADDR;
    end else if (stop) begin
      next_st = ST_IDLE;
    end else if (scl_fall) begin
      unique case (st)
        ST_IDLE: next_st = ST_IDLE;
        ST_ADDR: if (cnt == BYTE_BITS) next_st = addr_hit ? ST_AACK : ST_IDLE;
        ST_AACK: next_st = sh[RW_BIT] ? ST_RDAT : ST_CMD;
        ST_CMD:  if (cnt == BYTE_BITS) next_st = ST_CACK;
        ST_CACK: next_st = ST_WDAT;
        ST_WDAT: if (cnt == BYTE_BITS) next_st = ST_WACK;
        ST_WACK: next_st = ST_WDAT;
        ST_RDAT: if (cnt == BYTE_BITS) next_st = ST_RACK;
        ST_RACK: next_st = mst_ack ? ST_RDAT : ST_IDLE;
        default: next_st = ST_IDLE;
      endcase
    end
  end

  // State, edge history and bit counter
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st    <= ST_IDLE; // R8
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
    end else if (i_ce) begin
      st    <= next_st;
      scl_q <= f_scl;
      sda_q <= f_sda;
      if (start || next_st != st) begin
        cnt <= 4'h0;
      end else if (scl_rise) begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // Shift register, master ack and data line drive
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh       <= 8'h00;
      mst_ack  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (i_ce) begin
      sda_oe_n <= next_sda_oe_n;
      if (rd_load) begin
        sh <= rd_data; // R14
      end else if (st == ST_RDAT && scl_fall) begin
        sh <= {sh[6:0], 1'b0};
      end else if (shift_in) begin
        sh <= {sh[6:0], f_sda};
      end
      if (scl_rise && st == ST_RACK) begin
        mst_ack <= ~f_sda;
      end
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  // Pointer changes only on a command byte; writes go where it points
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr     <= CMD_INPUT;
      out_reg <= OUT_RST;
      pol     <= POL_RST;
      dir     <= DIR_RST; // R10
    end else if (i_ce) begin
      if (cmd_fire) begin
        ptr <= sh[1:0]; // R13 R14
      end
      if (wr_fire) begin
        unique case (ptr)
          CMD_INPUT:  ; // Input register ignores writes
          CMD_OUTPUT: out_reg <= sh; // R3
          CMD_POL:    pol <= sh;
          CMD_DIR:    dir <= sh; // R2
        endcase
      end
    end
  end

  // ==========================================================================
  // Input snapshot and interrupt
  // ==========================================================================
  // Snapshot taken once pins settle after reset and on every input read
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      settle    <= '0;
      init_done <= 1'b0;
      in_latch  <= 8'h00;
      int_oe_n  <= 1'b1;
    end else if (i_ce) begin
      int_oe_n <= ~int_cond; // R7
      if (!init_done) begin
        settle <= settle + 1'b1;
        if (settle == SW'(SETTLE_CYC)) begin
          init_done <= 1'b1;
          in_latch  <= f_port; // R3
        end
      end else if (rd_load && ptr == CMD_INPUT) begin
        in_latch <= f_port; // R15
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Open-drain lines only ever pull low
  assign o_sda_out   = 1'b0;
  assign o_sda_oe_n  = sda_oe_n;
  assign o_port_pin  = out_reg;
  assign o_port_oe_n = dir; // R16
  assign o_int_out   = 1'b0; // R7
  assign o_int_oe_n  = int_oe_n;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  a_dir_write: assert property ( // R2
    (i_ce && wr_fire && ptr == CMD_DIR) |=> (o_port_oe_n == $past(sh)))
    else $error("Direction write not applied to pins");

  a_out_write: assert property ( // R3
    (i_ce && wr_fire && ptr == CMD_OUTPUT) |=> (o_port_pin == $past(sh)))
    else $error("Output write not driven");

  a_input_ro: assert property ( // R1
    (i_ce && wr_fire && ptr == CMD_INPUT) |=> ($stable(out_reg) && $stable(pol) && $stable(dir)))
    else $error("Input register write changed a register");

  a_pol_read: assert property ( // R4
    (i_ce && rd_load && ptr == CMD_INPUT) |=> (sh == ($past(f_port) ^ $past(pol))))
    else $error("Input read ignores polarity");

  a_dir_read: assert property ( // R5
    (i_ce && rd_load && ptr == CMD_DIR) |=> (sh == $past(dir)))
    else $error("Direction readback wrong");

  a_int_set: assert property ( // R6
    (i_ce && int_cond) |=> (!o_int_oe_n && !o_int_out))
    else $error("Interrupt not pulled low on input change");

  a_int_clear: assert property ( // R15
    (i_ce && !int_cond) |=> o_int_oe_n)
    else $error("Interrupt not released");

  a_reset_idle: assert property ( // R8
    (!init_done && settle == '0) |-> (st == ST_IDLE && o_port_oe_n == DIR_RST &&
                                      o_port_pin == OUT_RST && o_sda_oe_n))
    else $error("Reset defaults missing");

  a_addr_ack: assert property ( // R9
    (i_ce && byte_done && st == ST_ADDR && addr_hit && !start && !stop)
      |=> (!o_sda_oe_n && st == ST_AACK))
    else $error("Own address not acknowledged");

  a_addr_nack: assert property ( // R9
    (i_ce && byte_done && st == ST_ADDR && !addr_hit && !start && !stop)
      |=> (o_sda_oe_n && st == ST_IDLE))
    else $error("Foreign address acknowledged");

  a_cmd_ack: assert property ( // R13
    (i_ce && cmd_fire && !start && !stop) |=> (!o_sda_oe_n && st == ST_CACK && ptr == $past(sh[1:0])))
    else $error("Command byte not taken");

  a_ptr_hold: assert property ( // R14
    $changed(ptr) |-> ($past(st) == ST_CMD))
    else $error("Pointer moved without command byte");

endmodule : iox_top

// *** include/iox_pkg.sv ***
// Shared constants and types for the two-wire eight-bit I/O expander
package iox_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SPIKE_NS      = 50;
  // Spike window in clock cycles, rounded up so a full spike is swallowed
  localparam int SPIKE_CYC     = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCL_MAX_KHZ   = 400;
  // Shortest serial clock half period in cycles, rounded down
  localparam int SCL_HALF_CYC  = 1000000000 / (SCL_MAX_KHZ * 2) / CLK_PERIOD_PS;
  // Cycles after reset before the input snapshot is trusted
  localparam int SETTLE_CYC    = SPIKE_CYC + 4;

  // ==========================================================================
  // Widths and bus framing
  // ==========================================================================
  localparam int       PORT_W    = 8;
  localparam int       STRAP_W   = 3;
  localparam int       FILT_W    = PORT_W + STRAP_W + 2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int       RW_BIT    = 0;
  localparam logic [3:0] ADDR_UPPER_DEF = 4'h4;

  // Filter reset levels: scl bit 0 and sda bit 1 idle high, the rest low
  localparam logic [FILT_W-1:0] FILT_RST = 13'h0003;

  // ==========================================================================
  // Command byte codes
  // ==========================================================================
  localparam logic [1:0] CMD_INPUT  = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_POL    = 2'h2;
  localparam logic [1:0] CMD_DIR    = 2'h3;

  // ==========================================================================
  // Register reset values
  // ==========================================================================
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;

  // ==========================================================================
  // Bus target states, Gray coded along the usual path
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_CMD  = 4'h2,
    ST_CACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WACK = 4'h5,
    ST_RDAT = 4'h4,
    ST_RACK = 4'hc
  } iox_state_t;

endpackage : iox_pkg

// *** rtl/iox_pin_filter.sv ***
// Three-stage synchroniser with spike filter for external pins
`timescale 1ns/1ps
module iox_pin_filter #(
  parameter int              W    = 1,
  parameter int              FILT = 1,
  parameter logic [W-1:0]    RST  = '0
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_ce,
  input  wire logic [W-1:0]  i_din,
  output logic      [W-1:0]  o_dout
);

  localparam int CW = $clog2(FILT + 1);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (FILT < 1) begin : g_bad_filt
    $error("Filter length must be at least one cycle");
  end

  // ==========================================================================
  // Per-bit filter
  // ==========================================================================
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic          s1;
    logic          s2;
    logic          s3;
    logic          stable;
    logic [CW-1:0] cnt;
    wire           agree = (s2 == s3) && (s3 != stable);

    // A level is accepted once stage two and three agree for FILT cycles
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        s1     <= RST[g];
        s2     <= RST[g];
        s3     <= RST[g];
        stable <= RST[g];
        cnt    <= '0;
      end else if (i_ce) begin
        s1 <= i_din[g];
        s2 <= s1;
        s3 <= s2;
        if (!agree) begin
          cnt <= '0;
        end else if (cnt == CW'(FILT - 1)) begin
          stable <= s3; // R12
          cnt    <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end

    assign o_dout[g] = stable;
  end

endmodule : iox_pin_filter

// *** verif/iox_bus_master.sv ***
// Behavioural two-wire bus master that drives the expander's serial pins
`timescale 1ns/1ps
module iox_bus_master #(
  parameter int QCYC = 125
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_low
);
  // ==========================================================================
  // Line control
  // ==========================================================================
  // Idle bus: clock held high, data released to the pull-up
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Quarter bit of a 400 kHz clock, stepped just after a clock edge
  task automatic wq();
    repeat (QCYC) @(posedge i_ref_clk);
    #1;
  endtask : wq

  // Start, or repeated start when the clock is already low
  task automatic start();
    if (o_scl == 1'b0) begin
      wq();
      o_sda_low = 1'b0;
      wq();
      o_scl = 1'b1;
    end
    wq();
    o_sda_low = 1'b1;
    wq();
    o_scl = 1'b0;
  endtask : start

  // One bit: data set in the low phase, sampled in the high phase
  task automatic xfer_bit(input logic v, output logic s);
    wq();
    o_sda_low = ~v;
    wq();
    o_scl = 1'b1;
    wq();
    s = i_sda_line;
    wq();
    o_scl = 1'b0;
  endtask : xfer_bit

  // Byte out, most significant bit first, then the target's answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], s);
    end
    xfer_bit(1'b1, ack);
  endtask : put_byte

  // Byte in, then master ack (drive low) or nack (release)
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, b[i]);
    end
    xfer_bit(~mack, s);
  endtask : get_byte

  // Stop: data rises while the clock is high, bus left idle
  task automatic stop();
    wq();
    o_sda_low = 1'b1;
    wq();
    o_scl = 1'b1;
    wq();
    o_sda_low = 1'b0;
    wq();
  endtask : stop
endmodule : iox_bus_master

// *** verif/iox_top_tb.sv ***
// Self-checking bench for the two-wire I/O expander
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, (e), (g)); end end
module iox_top_tb
  import iox_pkg::*;
;
  // ==========================================================================
  // Signals and wiring
  // ==========================================================================
  logic               i_ref_clk = 1'b0;
  logic               i_rstn    = 1'b0;
  logic               i_ce      = 1'b1;
  logic [STRAP_W-1:0] i_addr_strap;
  logic [PORT_W-1:0]  ext_pin;
  logic [31:0]        lfsr      = 32'h1da6;
  logic [6:0]         addr7;
  int                 failures  = 0;
  int                 checks_done = 0;
  wire                scl;
  wire                m_sda_low;
  wire                o_sda_out;
  wire                o_sda_oe_n;
  wire                o_int_out;
  wire                o_int_oe_n;
  wire [PORT_W-1:0]   o_port_pin;
  wire [PORT_W-1:0]   o_port_oe_n;
  wire                sda_line;
  wire                int_line;
  wire [PORT_W-1:0]   pin_line;

  // Open-drain lines with pull-ups; port pins driven by whichever side owns them
  assign sda_line = (m_sda_low | (~o_sda_oe_n & ~o_sda_out)) ? 1'b0 : 1'b1;
  assign int_line = (~o_int_oe_n & ~o_int_out) ? 1'b0 : 1'b1;
  assign pin_line = (~o_port_oe_n & o_port_pin) | (o_port_oe_n & ext_pin);

  // 200 MHz clock
  always #2.5 i_ref_clk = ~i_ref_clk;

  iox_top DUT (
    .i_ref_clk    (i_ref_clk),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_scl        (scl),
    .i_sda        (sda_line),
    .o_sda_out    (o_sda_out),
    .o_sda_oe_n   (o_sda_oe_n),
    .i_addr_strap (i_addr_strap),
    .i_port_pin   (pin_line),
    .o_port_pin   (o_port_pin),
    .o_port_oe_n  (o_port_oe_n),
    .o_int_out    (o_int_out),
    .o_int_oe_n   (o_int_oe_n)
  );

  iox_bus_master m (
    .i_ref_clk  (i_ref_clk),
    .i_sda_line (sda_line),
    .o_scl      (scl),
    .o_sda_low  (m_sda_low)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Next random byte from the shift register
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  // Expected input byte: pin levels, outputs showing their driven value, then inversion
  function automatic logic [7:0] exp_in(input logic [7:0] ext, input logic [7:0] dir,
                                         input logic [7:0] outv, input logic [7:0] pol);
    return ((dir & ext) | (~dir & outv)) ^ pol;
  endfunction : exp_in

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : wait_cyc

  // Command then n data bytes (earlier ones inverted), repeated start, one or two read bytes
  task automatic wr_rd(input logic [7:0] cmd, input logic [7:0] d, input int n,
                       input logic two, output logic [7:0] rb, output logic [7:0] rb2);
    logic ack;
    m.start();
    m.put_byte({addr7, 1'b0}, ack);
    `CHK("addr ack", 1'b0, ack)
    m.put_byte(cmd, ack);
    `CHK("cmd ack", 1'b0, ack)
    for (int i = n; i > 0; i--) begin
      m.put_byte((i > 1) ? ~d : d, ack);
      `CHK("data ack", 1'b0, ack)
    end
    m.start();
    m.put_byte({addr7, 1'b1}, ack);
    `CHK("read addr ack", 1'b0, ack)
    m.get_byte(two, rb);
    rb2 = 8'h00;
    if (two) begin
      m.get_byte(1'b0, rb2);
    end
    m.stop();
  endtask : wr_rd

  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    logic [7:0] v;
    logic [7:0] dirv;
    logic [7:0] outv;
    logic [7:0] polv;
    logic [7:0] rb;
    logic [7:0] rb2;
    logic       ack;
    v = rnd();
    i_addr_strap = v[2:0];
    addr7 = {ADDR_UPPER_DEF, v[2:0]};
    ext_pin = rnd();
    wait_cyc(2);
    i_rstn = 1'b1;
    `CHK("dir after reset", DIR_RST, o_port_oe_n)
    `CHK("out after reset", OUT_RST, o_port_pin)
    `CHK("sda idle", 1'b1, o_sda_oe_n)
    `CHK("int idle", 1'b1, o_int_oe_n)
    wait_cyc(200);
    // Neighbouring strap address is not answered
    m.start();
    m.put_byte({addr7 ^ 7'h01, 1'b0}, ack);
    `CHK("foreign addr", 1'b1, ack)
    m.stop();
    // Direction, output and polarity written and read back; direction and output also checked on the pins
    v = rnd();
    dirv = v | 8'h01;
    wr_rd({6'h00, CMD_DIR}, dirv, 2, 1'b0, rb, rb2);
    `CHK("dir pins", dirv, o_port_oe_n)
    `CHK("dir read", dirv, rb)
    outv = rnd();
    wr_rd({6'h00, CMD_OUTPUT}, outv, 1, 1'b0, rb, rb2);
    `CHK("out pins", outv, o_port_pin)
    `CHK("out read", outv, rb)
    polv = rnd();
    wr_rd({6'h00, CMD_POL}, polv, 1, 1'b0, rb, rb2);
    `CHK("pol read", polv, rb)
    // Snapshot from reset still matches, since input pins kept their level
    wait_cyc(40);
    `CHK("int quiet", 1'b1, int_line)
    // Change seen only once the clock enable returns; return clears
    i_ce = 1'b0;
    ext_pin[0] = ~ext_pin[0];
    wait_cyc(40);
    `CHK("int frozen", 1'b1, int_line)
    i_ce = 1'b1;
    wait_cyc(40);
    `CHK("int on change", 1'b0, int_line)
    `CHK("int value", 1'b0, o_int_out)
    ext_pin[0] = ~ext_pin[0];
    wait_cyc(40);
    `CHK("int on return", 1'b1, int_line)
    ext_pin[0] = ~ext_pin[0];
    wait_cyc(40);
    `CHK("int again", 1'b0, int_line)
    // Ignored write to the input register, then two reads that clear the interrupt
    wr_rd({6'h00, CMD_INPUT}, ~outv, 1, 1'b1, rb, rb2);
    `CHK("input ro", outv, o_port_pin)
    `CHK("input first", exp_in(ext_pin, dirv, outv, polv), rb)
    `CHK("input second", exp_in(ext_pin, dirv, outv, polv), rb2)
    wait_cyc(40);
    `CHK("int after read", 1'b1, int_line)
    close_out();
  end

  // Watchdog: the scenarios need about 110,000 cycles, give up at 120,000
  initial begin
    #600000;
    failures++;
    close_out();
  end
endmodule : iox_top_tb
